/* File: src/sdt_pkg.sv */
// sdt_pkg: register offsets, field positions, reset values and carrier types
// for the split dual byte timer control block.
// assumes one byte-wide register port per cycle and a 40 MHz mclk.
`default_nettype none
package sdt_pkg;
  // register offsets
  localparam logic [5:0] OFS_PRESC_EN  = 6'h00;
  localparam logic [5:0] OFS_CH_OE     = 6'h01;
  localparam logic [5:0] OFS_CH_IDLE   = 6'h02;
  localparam logic [5:0] OFS_SPLIT     = 6'h03;
  localparam logic [5:0] OFS_CMD_CLR   = 6'h04;
  localparam logic [5:0] OFS_CMD_SET   = 6'h05;
  localparam logic [5:0] OFS_INT_EN    = 6'h0A;
  localparam logic [5:0] OFS_INT_FLAG  = 6'h0B;
  localparam logic [5:0] OFS_LOW_CNT   = 6'h20;
  localparam logic [5:0] OFS_HIGH_CNT  = 6'h21;
  localparam logic [5:0] OFS_LOW_PER   = 6'h26;
  localparam logic [5:0] OFS_HIGH_PER  = 6'h27;
  localparam logic [5:0] OFS_LOW_CMP0  = 6'h28;
  localparam logic [5:0] OFS_HIGH_CMP0 = 6'h29;
  localparam logic [5:0] OFS_CMP_STEP  = 6'h02;

  // field positions
  localparam int NUM_CH        = 3;
  localparam int ENABLE_BIT    = 0;
  localparam int PRESC_LSB     = 1;
  localparam int SPLIT_BIT     = 0;
  localparam int CMD_LSB       = 2;
  localparam int HIGH_CH_LSB   = 4;
  localparam int LOW_UNF_BIT   = 0;
  localparam int HIGH_UNF_BIT  = 1;
  localparam int LOW_CMP_LSB   = 4;

  // masks and reset values
  localparam logic [7:0] PRESC_EN_MASK = 8'h0F;
  localparam logic [7:0] CH_MASK       = 8'h77;
  localparam logic [7:0] SPLIT_MASK    = 8'h01;
  localparam logic [7:0] STAT_MASK     = 8'h03;
  localparam logic [7:0] INT_MASK      = 8'h73;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CNT_RESET     = 8'h00;
  localparam logic [7:0] PER_RESET     = 8'hFF;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [9:0] PRESC_RESET   = 10'h000;

  // commands in the command field
  typedef enum logic [1:0] {
    SDT_CMD_NONE,
    SDT_CMD_UPDATE,
    SDT_CMD_RESTART,
    SDT_CMD_HARD_RESET
  } sdt_cmd_t;

  // one register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sdt_reg_req_t;
endpackage : sdt_pkg
`default_nettype wire

/* File: src/sdt_timer.sv */
// sdt_timer: split mode control of a timer as two 8-bit down-counters,
// three compare channels each, command pair, flags and interrupt request.
// assumes register requests and port values synchronous to mclk.
`default_nettype none
module sdt_timer (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire sdt_pkg::sdt_reg_req_t reg_req,
  output logic [7:0]                reg_rdata,
  input  wire logic [5:0]           port_out_value,
  output logic [5:0]                waveform_pin,
  output logic                      irq
);

  // prescaler bit mask: tick when all masked bits of the count are one
  function automatic logic [9:0] presc_mask(input logic [2:0] code);
    case (code)
      3'h0:    presc_mask = 10'h000;
      3'h1:    presc_mask = 10'h001;
      3'h2:    presc_mask = 10'h003;
      3'h3:    presc_mask = 10'h007;
      3'h4:    presc_mask = 10'h00F;
      3'h5:    presc_mask = 10'h03F;
      3'h6:    presc_mask = 10'h0FF;
      default: presc_mask = 10'h3FF;
    endcase
  endfunction : presc_mask

  // write strobe for one offset
  function automatic logic wr_at(input sdt_pkg::sdt_reg_req_t r, input logic [5:0] ofs);
    wr_at = r.wr && (r.addr == ofs);
  endfunction : wr_at

  // register state
  logic [7:0] presc_en_reg;
  logic [7:0] ch_oe_reg;
  logic [7:0] ch_idle_reg;
  logic [7:0] split_reg;
  logic [7:0] stat_reg;
  logic [7:0] int_en_reg;
  logic [7:0] flag_reg;
  logic [7:0] low_cnt_reg;
  logic [7:0] high_cnt_reg;
  logic [7:0] low_per_reg;
  logic [7:0] high_per_reg;
  logic [9:0] presc_reg;
  logic [5:0] wave_reg;
  logic [5:0] pin_reg;
  logic [7:0] rdata_reg;

  // next values of the state
  logic [7:0] stat_next;
  logic [7:0] flag_next;
  logic [7:0] low_cnt_next;
  logic [7:0] high_cnt_next;
  logic [9:0] presc_next;
  logic [5:0] wave_next;
  logic [5:0] pin_next;
  logic [7:0] rd_word;
  logic [7:0] rdata_next;

  // decoded controls and events
  wire logic [2:0] prescale_select;
  wire logic       enabled;
  wire logic       dual_byte_select;
  wire logic       run;
  wire logic [9:0] pmask;
  wire logic       tick;
  wire logic       cmd_clr_wr;
  wire logic       cmd_set_wr;
  wire logic       cmd_wr;
  wire sdt_pkg::sdt_cmd_t cmd;
  wire logic       do_restart;
  wire logic       do_hard;
  wire logic       wr_low_cnt;
  wire logic       wr_high_cnt;
  wire logic       low_unf;
  wire logic       high_unf;
  wire logic [2:0] low_match;
  wire logic [2:0] low_wave;
  wire logic [2:0] high_wave;
  wire logic [5:0] ch_oe;
  wire logic [5:0] ch_idle;
  wire logic [7:0] flag_set;
  wire logic [7:0] flag_clr;
  wire logic [7:0] stat_set;
  wire logic [7:0] stat_clr;
  logic [7:0] cmp_rd [sdt_pkg::NUM_CH];
  logic [7:0] cmp_rd_all;

  // control field decode
  assign prescale_select  = presc_en_reg[sdt_pkg::PRESC_LSB +: 3];
  assign enabled          = presc_en_reg[sdt_pkg::ENABLE_BIT];
  assign dual_byte_select = split_reg[sdt_pkg::SPLIT_BIT];
  // run gating by enable and split
  assign run              = enabled && dual_byte_select;
  assign pmask            = presc_mask(prescale_select);
  assign tick             = run && ((presc_reg & pmask) == pmask);

  // command pair decode
  assign cmd_clr_wr = wr_at(reg_req, sdt_pkg::OFS_CMD_CLR);
  assign cmd_set_wr = wr_at(reg_req, sdt_pkg::OFS_CMD_SET);
  assign cmd_wr     = cmd_clr_wr || cmd_set_wr;
  assign cmd        = sdt_pkg::sdt_cmd_t'(reg_req.wdata[sdt_pkg::CMD_LSB +: 2]);
  // restart always, hard reset only while disabled
  assign do_restart = cmd_wr && (cmd == sdt_pkg::SDT_CMD_RESTART);
  // a hard reset while running is dropped, the counters keep going
  assign do_hard    = cmd_wr && (cmd == sdt_pkg::SDT_CMD_HARD_RESET) && !enabled;

  // counter events
  assign wr_low_cnt  = wr_at(reg_req, sdt_pkg::OFS_LOW_CNT);
  assign wr_high_cnt = wr_at(reg_req, sdt_pkg::OFS_HIGH_CNT);
  assign low_unf     = tick && (low_cnt_reg == sdt_pkg::CNT_RESET) && !wr_low_cnt;
  assign high_unf    = tick && (high_cnt_reg == sdt_pkg::CNT_RESET) && !wr_high_cnt;

  // per-channel compare registers, match and waveform compare
  genvar n;
  generate
    for (n = 0; n < sdt_pkg::NUM_CH; n++) begin : g_ch
      // byte offsets of this channel's compares
      localparam logic [5:0] L_OFS = 6'(sdt_pkg::OFS_LOW_CMP0 + sdt_pkg::OFS_CMP_STEP * n);
      localparam logic [5:0] H_OFS = 6'(sdt_pkg::OFS_HIGH_CMP0 + sdt_pkg::OFS_CMP_STEP * n);
      logic [7:0] low_cmp_reg;
      logic [7:0] high_cmp_reg;
      // compare value storage, hard reset restores zero
      always_ff @(posedge mclk) begin
        if (rst || do_hard) begin
          low_cmp_reg  <= sdt_pkg::CMP_RESET;
          high_cmp_reg <= sdt_pkg::CMP_RESET;
        end else begin
          if (wr_at(reg_req, L_OFS)) low_cmp_reg <= reg_req.wdata;
          if (wr_at(reg_req, H_OFS)) high_cmp_reg <= reg_req.wdata;
        end
      end
      // compare against own byte counter, waveform continuously, low match only on a tick
      assign low_match[n] = tick && (low_cnt_reg == low_cmp_reg);
      assign low_wave[n]  = low_cnt_reg < low_cmp_reg;
      assign high_wave[n] = high_cnt_reg < high_cmp_reg;
      assign cmp_rd[n]    = (reg_req.addr == L_OFS) ? low_cmp_reg :
                            (reg_req.addr == H_OFS) ? high_cmp_reg : 8'h00;
    end
  endgenerate

  // merge compare read values
  always_comb begin
    cmp_rd_all = 8'h00;
    for (int i = 0; i < sdt_pkg::NUM_CH; i++) begin
      cmp_rd_all = cmp_rd_all | cmp_rd[i];
    end
  end

  // prescaler restarts on restart command or while stopped
  assign presc_next = (do_restart || do_hard || !run) ? sdt_pkg::PRESC_RESET
                                                      : presc_reg + 10'h001;

  // write first, then clear, then count or reload from period
  assign low_cnt_next  = wr_low_cnt ? reg_req.wdata :
                         (do_restart || do_hard) ? sdt_pkg::CNT_RESET :
                         !tick ? low_cnt_reg :
                         (low_cnt_reg == sdt_pkg::CNT_RESET) ? low_per_reg :
                         low_cnt_reg - 8'h01;
  // same priority on the high byte
  assign high_cnt_next = wr_high_cnt ? reg_req.wdata :
                         (do_restart || do_hard) ? sdt_pkg::CNT_RESET :
                         !tick ? high_cnt_reg :
                         (high_cnt_reg == sdt_pkg::CNT_RESET) ? high_per_reg :
                         high_cnt_reg - 8'h01;

  // flag layout: compare matches in 6:4, underflows in 1:0
  // sticky flags, set wins over a write-one clear
  assign flag_set  = {1'b0, low_match, 2'b00, high_unf, low_unf};
  assign flag_clr  = wr_at(reg_req, sdt_pkg::OFS_INT_FLAG) ? reg_req.wdata : 8'h00;
  assign flag_next = do_hard ? sdt_pkg::CTRL_RESET
                             : ((flag_reg & ~flag_clr) | flag_set) & sdt_pkg::INT_MASK;

  // status bits set and cleared one by one
  assign stat_set  = cmd_set_wr ? reg_req.wdata : 8'h00;
  assign stat_clr  = cmd_clr_wr ? reg_req.wdata : 8'h00;
  // only one of the pair is written per cycle, so set and clear never meet
  assign stat_next = do_hard ? sdt_pkg::CTRL_RESET :
                     ((stat_reg | stat_set) & ~stat_clr) & sdt_pkg::STAT_MASK;

  // channel bits gathered low channels first, then high channels
  assign ch_oe   = {ch_oe_reg[sdt_pkg::HIGH_CH_LSB +: 3], ch_oe_reg[2:0]};
  assign ch_idle = {ch_idle_reg[sdt_pkg::HIGH_CH_LSB +: 3], ch_idle_reg[2:0]};
  // idle values load the generator while disabled
  assign wave_next = do_hard ? 6'h00 :
                     enabled ? {high_wave, low_wave} :
                     ch_idle;
  // enabled channels override the port value
  assign pin_next  = (ch_oe & wave_reg) | (~ch_oe & port_out_value);

  // read mux, shared status and zero command field
  always_comb begin
    case (reg_req.addr)
      sdt_pkg::OFS_PRESC_EN: rd_word = presc_en_reg;
      sdt_pkg::OFS_CH_OE:    rd_word = ch_oe_reg;
      sdt_pkg::OFS_CH_IDLE:  rd_word = ch_idle_reg;
      sdt_pkg::OFS_SPLIT:    rd_word = split_reg;
      sdt_pkg::OFS_CMD_CLR:  rd_word = stat_reg;
      sdt_pkg::OFS_CMD_SET:  rd_word = stat_reg;
      sdt_pkg::OFS_INT_EN:   rd_word = int_en_reg;
      sdt_pkg::OFS_INT_FLAG: rd_word = flag_reg;
      sdt_pkg::OFS_LOW_CNT:  rd_word = low_cnt_reg;
      sdt_pkg::OFS_HIGH_CNT: rd_word = high_cnt_reg;
      sdt_pkg::OFS_LOW_PER:  rd_word = low_per_reg;
      sdt_pkg::OFS_HIGH_PER: rd_word = high_per_reg;
      default:               rd_word = cmp_rd_all;
    endcase
  end
  // read data is held between reads
  assign rdata_next = reg_req.rd ? rd_word : rdata_reg;

  // software control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      presc_en_reg <= sdt_pkg::CTRL_RESET;
      ch_oe_reg    <= sdt_pkg::CTRL_RESET;
      ch_idle_reg  <= sdt_pkg::CTRL_RESET;
      split_reg    <= sdt_pkg::CTRL_RESET;
      int_en_reg   <= sdt_pkg::CTRL_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == sdt_pkg::OFS_PRESC_EN)
        presc_en_reg <= reg_req.wdata & sdt_pkg::PRESC_EN_MASK;
      if (reg_req.addr == sdt_pkg::OFS_CH_OE)
        ch_oe_reg    <= reg_req.wdata & sdt_pkg::CH_MASK;
      if (reg_req.addr == sdt_pkg::OFS_CH_IDLE)
        ch_idle_reg  <= reg_req.wdata & sdt_pkg::CH_MASK;
      if (reg_req.addr == sdt_pkg::OFS_SPLIT)
        split_reg    <= reg_req.wdata & sdt_pkg::SPLIT_MASK;
      if (reg_req.addr == sdt_pkg::OFS_INT_EN)
        int_en_reg   <= reg_req.wdata & sdt_pkg::INT_MASK;
    end
  end

  // period registers hold each counter top
  always_ff @(posedge mclk) begin
    if (rst || do_hard) begin
      low_per_reg  <= sdt_pkg::PER_RESET;
      high_per_reg <= sdt_pkg::PER_RESET;
    end else begin
      if (wr_at(reg_req, sdt_pkg::OFS_LOW_PER))  low_per_reg  <= reg_req.wdata;
      if (wr_at(reg_req, sdt_pkg::OFS_HIGH_PER)) high_per_reg <= reg_req.wdata;
    end
  end

  // counting state, flags, waveform and read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      presc_reg    <= sdt_pkg::PRESC_RESET;
      low_cnt_reg  <= sdt_pkg::CNT_RESET;
      high_cnt_reg <= sdt_pkg::CNT_RESET;
      flag_reg     <= sdt_pkg::CTRL_RESET;
      stat_reg     <= sdt_pkg::CTRL_RESET;
      wave_reg     <= 6'h00;
      pin_reg      <= 6'h00;
      rdata_reg    <= 8'h00;
    end else begin
      presc_reg    <= presc_next;
      low_cnt_reg  <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
      flag_reg     <= flag_next;
      stat_reg     <= stat_next;
      wave_reg     <= wave_next;
      pin_reg      <= pin_next;
      rdata_reg    <= rdata_next;
    end
  end

  // outputs straight from flip-flops, irq from two registers
  assign reg_rdata    = rdata_reg;
  assign waveform_pin = pin_reg;
  // request while any enabled flag stands
  assign irq          = |(flag_reg & int_en_reg);

endmodule : sdt_timer
`default_nettype wire

/* File: dv/sdt_timer_chk.sv */
// sdt_timer_chk: port-level assertions for the split dual byte timer.
// assumes one mclk domain, synchronous active-high rst, bound to sdt_timer.
`default_nettype none
module sdt_timer_chk (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire sdt_pkg::sdt_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic [5:0]            port_out_value,
  input wire logic [5:0]            waveform_pin,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic      [7:0] oe_reg;
  logic      [7:0] oe_next;
  wire logic [5:0] oe_m = {oe_reg[6:4], oe_reg[2:0]};
  wire logic [5:0] a    = reg_req.addr;
  wire logic       rd   = reg_req.rd;
  wire logic       wr   = reg_req.wr;
  wire logic       stat = a inside {6'h04, 6'h05};
  wire logic       mapped = a <= 6'h05 || a inside {6'h0A, 6'h0B, 6'h20, 6'h21, [6'h26:6'h2D]};

  // shadow of the channel output enables
  assign oe_next = (wr && a == 6'h01) ? reg_req.wdata : oe_reg;
  always_ff @(posedge mclk) oe_reg <= rst ? 8'h00 : oe_next;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  pin_select_a: assert property (
    1'b1 |=> ((waveform_pin ^ $past(port_out_value)) & ~$past(oe_m)) == 6'h00)
    else $error("pin ignores port value");
  unmapped_zero_a: assert property (
    rd && !mapped |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  cmd_zero_a: assert property (
    rd && stat |=> reg_rdata[7:2] == 6'h00) else $error("command field read back");
  int_bits_a: assert property (
    rd && a inside {6'h0A, 6'h0B} |=> (reg_rdata & 8'h8C) == 8'h00)
    else $error("reserved interrupt bit");
  status_set_a: assert property (
    wr && a == 6'h05 && reg_req.wdata[3:2] != 2'b11 ##1 !wr ##1 rd && stat
    |=> (reg_rdata & $past(reg_req.wdata, 3) & 8'h03) == ($past(reg_req.wdata, 3) & 8'h03))
    else $error("status bit not set");
  status_clear_a: assert property (
    wr && a == 6'h04 ##1 !wr ##1 rd && stat
    |=> (reg_rdata & $past(reg_req.wdata, 3) & 8'h03) == 8'h00) else $error("status bit kept");
  status_same_a: assert property (
    rd && a == 6'h04 ##1 !wr ##1 rd && a == 6'h05
    |=> ((reg_rdata ^ $past(reg_rdata, 2)) & 8'h03) == 8'h00) else $error("status views differ");
  readback_a: assert property (
    wr && a inside {[6'h26:6'h2D]} ##1 !wr ##1 rd && a == $past(a, 2)
    |=> reg_rdata == $past(reg_req.wdata, 3)) else $error("period or compare lost");
  irq_off_a: assert property (
    wr && a == 6'h0A && reg_req.wdata == 8'h00 |=> !irq) else $error("irq without enable");
endmodule : sdt_timer_chk

bind sdt_timer sdt_timer_chk u_sdt_timer_chk (.mclk(mclk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .port_out_value(port_out_value), .waveform_pin(waveform_pin),
  .irq(irq));
`default_nettype wire

/* File: dv/sdt_port_model.sv */
// sdt_port_model: port output register standing behind the waveform pins.
// assumes mclk from the bench; value changes at each falling edge.
`default_nettype none
module sdt_port_model (
  input  wire logic       mclk,
  output var  logic [5:0] port_out_value
);
  timeunit 1ns;
  timeprecision 1ps;
  // fresh port value every cycle so pin selection is exercised
  initial begin
    port_out_value = 6'h00;
    forever begin
      @(negedge mclk);
      port_out_value = 6'($urandom);
    end
  end
endmodule : sdt_port_model
`default_nettype wire

/* File: dv/tb_sdt_timer.sv */
// tb_sdt_timer: self-checking bench for the split dual byte timer control.
// assumes sdt_timer, its bound checker and sdt_port_model are compiled.
`default_nettype none
module tb_sdt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk;
  logic                  rst;
  sdt_pkg::sdt_reg_req_t reg_req;
  logic [7:0]            reg_rdata;
  logic [5:0]            port_out_value;
  logic [5:0]            waveform_pin;
  logic                  irq;
  int                    num_errors;
  int                    tests_run;
  logic [7:0]            d;
  logic [7:0]            r;
  logic [5:0]            a;
  logic [5:0]            offs [15] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0A, 6'h26, 6'h27,
                                       6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h0E, 6'h3F};

  sdt_timer u_sdt_timer (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .port_out_value(port_out_value), .waveform_pin(waveform_pin), .irq(irq));
  sdt_port_model u_sdt_port_model (.mclk(mclk), .port_out_value(port_out_value));

  // readable bits per offset
  function automatic logic [7:0] mask_of(input logic [5:0] x);
    case (x)
      6'h00: return 8'h0F;
      6'h01, 6'h02: return 8'h77;
      6'h03: return 8'h01;
      6'h0A: return 8'h73;
      6'h0E, 6'h3F: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : mask_of
  function automatic int div_of(input int c);
    return (c < 5) ? (1 << c) : (16 << (2 * (c - 4)));
  endfunction : div_of

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one register access, request held over one rising edge
  task automatic acc(input logic w, input logic [5:0] x, input logic [7:0] v);
    @(negedge mclk);
    reg_req = '{wr: w, rd: !w, addr: x, wdata: v};
    @(negedge mclk);
    reg_req = '0;
    r = reg_rdata;
  endtask : acc
  task automatic rd_chk(input logic [5:0] x, input logic [7:0] exp);
    acc(1'b0, x, 8'h00);
    chk(r, exp);
  endtask : rd_chk
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  initial begin
    reg_req = '0;
    rst = 1'b1;
    num_errors = 0;
    tests_run = 0;
    d = 8'($urandom(32'hF18E));
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    foreach (offs[i]) rd_chk(offs[i], (offs[i] inside {6'h26, 6'h27}) ? 8'hFF : 8'h00);
    done("reset");
    for (int i = 0; i < 40; i++) begin
      a = offs[$urandom_range(14, 0)];
      d = 8'($urandom);
      acc(1'b1, a, d);
      rd_chk(a, d & mask_of(a));
    end
    acc(1'b1, 6'h00, 8'h00);
    done("readback");
    acc(1'b1, 6'h05, 8'h07);
    rd_chk(6'h04, 8'h03);
    rd_chk(6'h05, 8'h03);
    acc(1'b1, 6'h04, 8'h01);
    rd_chk(6'h05, 8'h02);
    acc(1'b1, 6'h20, 8'h33);
    acc(1'b1, 6'h04, 8'h0A);
    rd_chk(6'h20, 8'h00);
    rd_chk(6'h04, 8'h00);
    done("commands");
    acc(1'b1, 6'h03, 8'h01);
    acc(1'b1, 6'h26, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 6'h20, 8'h80);
      acc(1'b1, 6'h00, {4'h0, 3'(c), 1'b1});
      repeat (3 * div_of(c) - 1) @(negedge mclk);
      rd_chk(6'h20, 8'h7D);
      acc(1'b1, 6'h00, 8'h00);
    end
    acc(1'b1, 6'h20, 8'h55);
    repeat (20) @(negedge mclk);
    rd_chk(6'h20, 8'h55);
    acc(1'b1, 6'h03, 8'h00);
    acc(1'b1, 6'h00, 8'h01);
    repeat (20) @(negedge mclk);
    rd_chk(6'h20, 8'h55);
    acc(1'b1, 6'h00, 8'h00);
    acc(1'b1, 6'h03, 8'h01);
    done("prescaler");
    acc(1'b1, 6'h0B, 8'h73);
    foreach (offs[i]) if (i >= 5 && i <= 9) acc(1'b1, offs[i], 8'h10);
    acc(1'b1, 6'h26, 8'h02);
    acc(1'b1, 6'h20, 8'h00);
    acc(1'b1, 6'h28, 8'h01);
    acc(1'b1, 6'h2C, 8'h02);
    acc(1'b1, 6'h27, 8'h03);
    acc(1'b1, 6'h21, 8'h02);
    acc(1'b1, 6'h0A, 8'h01);
    acc(1'b1, 6'h00, 8'h01);
    repeat (8) @(negedge mclk);
    acc(1'b1, 6'h20, 8'h40);
    rd_chk(6'h20, 8'h3F);
    acc(1'b1, 6'h00, 8'h00);
    rd_chk(6'h0B, 8'h53);
    chk({7'h00, irq}, 8'h01);
    acc(1'b1, 6'h0B, 8'h01);
    rd_chk(6'h0B, 8'h52);
    chk({7'h00, irq}, 8'h00);
    acc(1'b1, 6'h0A, 8'h40);
    chk({7'h00, irq}, 8'h01);
    acc(1'b1, 6'h0B, 8'h20);
    rd_chk(6'h0B, 8'h52);
    acc(1'b1, 6'h0B, 8'h02);
    rd_chk(6'h0B, 8'h50);
    acc(1'b1, 6'h0A, 8'h00);
    chk({7'h00, irq}, 8'h00);
    done("flags");
    acc(1'b1, 6'h00, 8'h01);
    acc(1'b1, 6'h04, 8'h0C);
    rd_chk(6'h26, 8'h02);
    acc(1'b1, 6'h00, 8'h00);
    acc(1'b1, 6'h05, 8'h0C);
    rd_chk(6'h26, 8'hFF);
    rd_chk(6'h0B, 8'h00);
    done("hard reset");
    acc(1'b1, 6'h01, 8'h77);
    repeat (6) begin
      d = 8'($urandom) & 8'h77;
      acc(1'b1, 6'h02, d);
      repeat (2) @(negedge mclk);
      chk({2'b00, waveform_pin}, {2'b00, d[6:4], d[2:0]});
    end
    acc(1'b1, 6'h01, 8'h03);
    acc(1'b1, 6'h2A, 8'hFF);
    acc(1'b1, 6'h20, 8'h80);
    acc(1'b1, 6'h00, 8'h01);
    repeat (4) @(negedge mclk);
    chk({6'h00, waveform_pin[1:0]}, 8'h02);
    done("waveform");
    conclude();
  end
endmodule : tb_sdt_timer
`default_nettype wire
